// ### pkg/phase_shed_map.svh
// Contract
// - input current read reports full scale as 1fh
// - flag input overcurrent at selectable trip level
// - first trip point from threshold resistor level
// - trip points spaced by first trip over K
// - hysteresis from shedding config bits 5:4
// - K from bits 3:2, first trip bits 7:6
// - shedding off by mode bit 2 or grounded pin
// - disabled shedding runs programmed phase count
// - fast phase-add event enable in mode register
// - fast add event restores every dropped phase
// - without fast add, restore on reset or retry
// - minimum phases default 1, or the low-power count in low-power state one, overridable
// - fixed drop order by populated phase count
// - pulse dropped low-side drive above 20kHz
// - stop refresh pulses once reference reaches 0.60V
// - five-bit offset trim on load monitor
`ifndef PHASE_SHED_MAP_SVH
`define PHASE_SHED_MAP_SVH
`define ADDR_INPUT_CURRENT   8'h89
`define ADDR_SHED_CONFIG     8'hd1
`define ADDR_MODE_CONTROL    8'hd4
`define ADDR_OFFSET_TRIM     8'he4
`define ADDR_OC_CONFIG       8'hf6
`define RST_SHED_CONFIG      8'h00
`define RST_MODE_CONTROL     8'h08
`define RST_OFFSET_TRIM      8'h00
`define RST_OC_CONFIG        8'h00
`define MODE_AUTO_OFF_BIT    2
`define MODE_FAST_ADD_BIT    3
`define CFG_MINPH_LSB        0
`define CFG_K_LSB            2
`define CFG_HYST_LSB         4
`define CFG_I1_LSB           6
`define OC_TRIP_LSB          5
`define TRIM_LSB             0
`define IIN_FULL_CODE        8'h1f
`define IIN_SHIFT            2
`define OC_TRIP_BASE         8'h2e
`define REF_STOP_CODE        10'h03c
`define REF_ZERO_CODE        10'h000
`define REFRESH_FREQ_KHZ     21
`define CLK_FREQ_KHZ         25000
`define REFRESH_CYCLES       (`CLK_FREQ_KHZ / `REFRESH_FREQ_KHZ)
`define REFRESH_PULSE_CYC    11'h004
`define TRIP_UNIT_SHIFT      4
`endif

// ### pkg/phase_shed_pkg.sv
package phase_shed_pkg;
	typedef enum logic [1:0] {
		SHED_SOFTSTART = 2'b00,
		SHED_FIXED     = 2'b01,
		SHED_AUTO      = 2'b10
	} shed_state_t;
	typedef logic [2:0] phase_count_t;
	typedef logic [5:0] phase_mask_t;
endpackage

// ### rtl/boot_refresh.sv
`timescale 1ns/10ps
`default_nettype none
`include "phase_shed_map.svh"
module boot_refresh (
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	input  wire phase_shed_pkg::phase_mask_t droppedMask,
	input  wire logic [9:0]                  refDac,
	output logic [5:0]                       lowSideRefresh
);
	localparam logic [10:0] PERIOD = 11'(`REFRESH_CYCLES);
	logic [10:0] tick;
	logic        refreshOn;
	logic        pulseWin;

	assign refreshOn = refDac > `REF_STOP_CODE;
	assign pulseWin  = tick < `REFRESH_PULSE_CYC;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tick <= 11'h000;
		end else if (tick >= PERIOD - 11'h001) begin
			tick <= 11'h000;
		end else begin
			tick <= tick + 11'h001;
		end
	end

	// registered so drives stay glitch free
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lowSideRefresh <= 6'h00;
		end else begin
			lowSideRefresh <= (pulseWin && refreshOn) ? droppedMask : 6'h00;
		end
	end

	refresh_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!$past(refreshOn) |-> lowSideRefresh == 6'h00)
		else $error("refresh pulse below stop level");
	refresh_mask_a: assert property (@(posedge core_clk) disable iff (!resetn)
		(lowSideRefresh & ~$past(droppedMask)) == 6'h00)
		else $error("refresh on active phase");
endmodule
`default_nettype wire

// ### rtl/phase_shed_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "phase_shed_map.svh"
module phase_shed_ctrl (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWrite,
	output logic [7:0]       regRdata,
	// sensing, already digitised on this clock
	input  wire logic [7:0]  inputSenseCode,
	input  wire logic [9:0]  loadCurrentMonitor,
	input  wire logic [7:0]  thresholdLevel,
	input  wire logic [9:0]  refDac,
	// pins
	input  wire logic        thresholdPinLow,
	input  wire logic [2:0]  unusedPhaseHigh,
	input  wire logic        fastPhaseAddEvent,
	input  wire logic        overcurrentRetry,
	input  wire logic        softStartDone,
	input  wire logic        lowPowerStateOne,
	input  wire logic [2:0]  lowPowerPhaseCount,
	input  wire logic [2:0]  programmedPhases,
	output logic [5:0]       phaseEnable,
	output logic [5:0]       lowSideRefresh,
	output logic             inputOvercurrent,
	output logic [2:0]       activePhases
);
	logic [7:0] shedConfig;
	logic [7:0] modeControl;
	logic [7:0] offsetTrim;
	logic [7:0] ocConfig;
	logic [7:0] inputReading;
	phase_shed_pkg::shed_state_t state;
	phase_shed_pkg::shed_state_t next_state;
	phase_shed_pkg::phase_count_t populated;
	phase_shed_pkg::phase_count_t minPhases;
	phase_shed_pkg::phase_count_t next_active;
	phase_shed_pkg::phase_mask_t  next_enable;
	logic [2:0]  pinSync1;
	logic [2:0]  pinSync2;
	logic [2:0]  evtSync1;
	logic [2:0]  evtSync2;
	logic        evtPrev;
	logic        autoOff;
	logic        fastAddOn;
	logic        fastAddPulse;
	logic        restoreAll;
	logic [9:0]  trimmedLoad;
	logic [11:0] firstTrip;
	logic [11:0] dropLevel;
	logic [11:0] addLevel;
	logic [11:0] hyst;
	logic        dropNow;
	logic        addNow;
	logic [7:0]  ocTrip;
	logic [7:0]  scaledIin;

	// trip current of a given phase count
	function automatic logic [11:0] tripOf(input logic [11:0] i1, input logic [1:0] kSel,
		input logic [2:0] n);
		logic [11:0] step;
		// widened so the largest K select does not wrap to a zero shift
		step = i1 >> ({1'b0, kSel} + 3'h1);
		tripOf = i1 + 12'(step * 12'(n - 3'h1));
	endfunction

	// unused-phase, threshold, retry and fast-add pins pass two flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pinSync1 <= 3'h0;
			pinSync2 <= 3'h0;
			evtSync1 <= 3'h0;
			evtSync2 <= 3'h0;
		end else begin
			pinSync1 <= unusedPhaseHigh;
			pinSync2 <= pinSync1;
			evtSync1 <= {fastPhaseAddEvent, overcurrentRetry, thresholdPinLow};
			evtSync2 <= evtSync1;
		end
	end

	// populated count from first high unused output
	assign populated = pinSync2[0] ? 3'h3 : pinSync2[1] ? 3'h4 : pinSync2[2] ? 3'h5 : 3'h6;

	// register writes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shedConfig  <= `RST_SHED_CONFIG;
			modeControl <= `RST_MODE_CONTROL;
			offsetTrim  <= `RST_OFFSET_TRIM;
			ocConfig    <= `RST_OC_CONFIG;
		end else if (regWrite) begin
			if (regAddr == `ADDR_SHED_CONFIG) shedConfig <= regWdata;
			if (regAddr == `ADDR_MODE_CONTROL) modeControl <= regWdata;
			if (regAddr == `ADDR_OFFSET_TRIM) offsetTrim <= {3'h0, regWdata[4:0]};
			if (regAddr == `ADDR_OC_CONFIG) ocConfig <= regWdata;
		end
	end

	// either the mode bit or a grounded pin
	assign autoOff   = modeControl[`MODE_AUTO_OFF_BIT] | evtSync2[0];
	assign fastAddOn = modeControl[`MODE_FAST_ADD_BIT];
	assign fastAddPulse = evtSync2[2] & ~evtPrev;
	assign restoreAll = (fastAddOn & fastAddPulse) | evtSync2[1];

	// offset trim subtracts, floor at zero
	assign trimmedLoad = (loadCurrentMonitor > {5'h00, offsetTrim[4:0]}) ?
		loadCurrentMonitor - {5'h00, offsetTrim[4:0]} : 10'h000;

	// resistor level sets first trip, scaled by selection
	assign firstTrip = 12'({4'h0, thresholdLevel} << `TRIP_UNIT_SHIFT) +
		12'({4'h0, thresholdLevel} << shedConfig[`CFG_I1_LSB +: 2]);
	assign hyst = firstTrip >> (3'h4 - {1'b0, shedConfig[`CFG_HYST_LSB +: 2]});
	assign dropLevel = tripOf(firstTrip, shedConfig[`CFG_K_LSB +: 2], activePhases - 3'h1);
	assign addLevel = tripOf(firstTrip, shedConfig[`CFG_K_LSB +: 2], activePhases) + hyst;
	assign dropNow = {2'h0, trimmedLoad} < dropLevel;
	assign addNow  = {2'h0, trimmedLoad} > addLevel;

	// minimum phases, field overrides when nonzero
	assign minPhases = (shedConfig[`CFG_MINPH_LSB +: 2] != 2'h0) ?
		{1'b0, shedConfig[`CFG_MINPH_LSB +: 2]} :
		(lowPowerStateOne ? lowPowerPhaseCount : 3'h1);

	// mode selection
	always_comb begin
		next_state = state;
		unique case (state)
			phase_shed_pkg::SHED_SOFTSTART: if (softStartDone) begin
				next_state = autoOff ? phase_shed_pkg::SHED_FIXED : phase_shed_pkg::SHED_AUTO;
			end
			phase_shed_pkg::SHED_FIXED: if (!autoOff) begin
				next_state = phase_shed_pkg::SHED_AUTO;
			end
			phase_shed_pkg::SHED_AUTO: if (autoOff) begin
				next_state = phase_shed_pkg::SHED_FIXED;
			end
			default: next_state = phase_shed_pkg::SHED_SOFTSTART;
		endcase
	end

	// phase count update
	always_comb begin
		next_active = activePhases;
		if (state == phase_shed_pkg::SHED_SOFTSTART) begin
			next_active = populated;
		end else if (state == phase_shed_pkg::SHED_FIXED) begin
			next_active = (programmedPhases == 3'h0 || programmedPhases > populated) ?
				populated : programmedPhases;
		end else if (restoreAll) begin
			next_active = populated;
		end else if (dropNow && activePhases > minPhases && activePhases > 3'h1) begin
			next_active = activePhases - 3'h1;
		end else if (addNow && fastAddOn && activePhases < populated) begin
			// rising load re-adds only with fast add enabled
			next_active = activePhases + 3'h1;
		end
	end

	// drop order tables by populated count
	always_comb begin
		next_enable = 6'h3f;
		unique case (populated)
			3'h6: case (next_active)
				3'h1: next_enable = 6'h01;
				3'h2: next_enable = 6'h09;
				3'h3: next_enable = 6'h0b;
				3'h4: next_enable = 6'h1b;
				3'h5: next_enable = 6'h1f;
				default: next_enable = 6'h3f;
			endcase
			3'h5: case (next_active)
				3'h1: next_enable = 6'h01;
				3'h2: next_enable = 6'h05;
				3'h3: next_enable = 6'h07;
				3'h4: next_enable = 6'h0f;
				default: next_enable = 6'h1f;
			endcase
			3'h4: case (next_active)
				3'h1: next_enable = 6'h01;
				3'h2: next_enable = 6'h05;
				3'h3: next_enable = 6'h07;
				default: next_enable = 6'h0f;
			endcase
			default: case (next_active)
				3'h1: next_enable = 6'h01;
				3'h2: next_enable = 6'h03;
				default: next_enable = 6'h07;
			endcase
		endcase
	end

	// state and phase registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state        <= phase_shed_pkg::SHED_SOFTSTART;
			activePhases <= 3'h6;
			phaseEnable  <= 6'h3f;
			evtPrev      <= 1'b0;
		end else begin
			state        <= next_state;
			activePhases <= next_active;
			phaseEnable  <= next_enable;
			evtPrev      <= evtSync2[2];
		end
	end

	// saturating input reading, full scale 1fh
	assign scaledIin = inputSenseCode >> `IIN_SHIFT;
	// trip table, 0 is the 15uA default
	assign ocTrip = `OC_TRIP_BASE + 8'({ocConfig[`OC_TRIP_LSB +: 2], 3'h0});

	// telemetry and fault registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			inputReading     <= 8'h00;
			inputOvercurrent <= 1'b0;
		end else begin
			inputReading     <= (scaledIin > `IIN_FULL_CODE) ? `IIN_FULL_CODE : scaledIin;
			inputOvercurrent <= inputSenseCode >= ocTrip;
		end
	end

	// read mux, unmapped reads zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 8'h00;
		end else begin
			unique case (regAddr)
				`ADDR_INPUT_CURRENT: regRdata <= inputReading;
				`ADDR_SHED_CONFIG:   regRdata <= shedConfig;
				`ADDR_MODE_CONTROL:  regRdata <= modeControl;
				`ADDR_OFFSET_TRIM:   regRdata <= offsetTrim;
				`ADDR_OC_CONFIG:     regRdata <= ocConfig;
				default:             regRdata <= 8'h00;
			endcase
		end
	end

	boot_refresh refresher (
		.core_clk       (core_clk),
		.resetn         (resetn),
		.droppedMask    (~phaseEnable),
		.refDac         (refDac),
		.lowSideRefresh (lowSideRefresh)
	);

	// restore request while shedding is live
	sequence restoreSeen;
		restoreAll && state == phase_shed_pkg::SHED_AUTO;
	endsequence
	// one phase about to be shed
	sequence dropStep;
		state == phase_shed_pkg::SHED_AUTO && !restoreAll && next_active < activePhases;
	endsequence
	// one phase about to come back on rising load
	sequence addStep;
		state == phase_shed_pkg::SHED_AUTO && !restoreAll && next_active > activePhases;
	endsequence
	restore_all_a: assert property (@(posedge core_clk) disable iff (!resetn)
		restoreSeen |=> activePhases == populated)
		else $error("restore did not enable all phases");
	iin_sat_a: assert property (@(posedge core_clk) disable iff (!resetn)
		inputReading <= `IIN_FULL_CODE)
		else $error("input reading above full scale");
	min_phase_a: assert property (@(posedge core_clk) disable iff (!resetn)
		dropStep |-> next_active >= minPhases && dropNow)
		else $error("dropped below minimum");
	add_margin_a: assert property (@(posedge core_clk) disable iff (!resetn)
		addStep |-> addNow && fastAddOn)
		else $error("phase added inside hysteresis");
	auto_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
		state == phase_shed_pkg::SHED_AUTO && autoOff
		|=> state == phase_shed_pkg::SHED_FIXED)
		else $error("shedding not disabled");
	// no rising add with fast add disabled
	no_add_a: assert property (@(posedge core_clk) disable iff (!resetn)
		state == phase_shed_pkg::SHED_AUTO && !fastAddOn && !evtSync2[1]
		|=> activePhases <= $past(activePhases))
		else $error("phase added without restore");
	phase_one_a: assert property (@(posedge core_clk) disable iff (!resetn)
		phaseEnable[0])
		else $error("phase one dropped");
	fixed_count_a: assert property (@(posedge core_clk) disable iff (!resetn)
		state == phase_shed_pkg::SHED_FIXED && programmedPhases != 3'h0 &&
		programmedPhases <= populated |=> activePhases == $past(programmedPhases))
		else $error("fixed count not applied");
	// trip flag follows the level one cycle later
	oc_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
		inputOvercurrent == $past(inputSenseCode >= ocTrip))
		else $error("input overcurrent flag wrong");
	// full scale input reads the full code
	iin_full_a: assert property (@(posedge core_clk) disable iff (!resetn)
		inputSenseCode >= 8'(`IIN_FULL_CODE << `IIN_SHIFT)
		|=> inputReading == `IIN_FULL_CODE)
		else $error("full scale reading wrong");
endmodule
`default_nettype wire

// ### dv/power_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
// drivers on the far side; records refresh pulses per phase
module power_stage_model #(
	parameter int POPULATED = 6
) (
	input  wire logic       core_clk,
	input  wire logic [5:0] phaseEnable,
	input  wire logic [5:0] lowSideRefresh,
	input  wire logic       clearSeen,
	output logic [2:0]      unusedPhaseHigh,
	output logic [5:0]      refreshSeen
);
	assign unusedPhaseHigh = (POPULATED == 5) ? 3'h4 : (POPULATED == 4) ? 3'h2 :
		(POPULATED == 3) ? 3'h1 : 3'h0;
	// sticky record, cleared by the bench between windows
	always @(posedge core_clk) begin
		if (clearSeen) begin
			refreshSeen <= 6'h00;
		end else begin
			refreshSeen <= refreshSeen | lowSideRefresh;
		end
	end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "phase_shed_map.svh"
module tb_top;
	logic       core_clk, resetn, regWrite, fastPhaseAddEvent, overcurrentRetry;
	logic       softStartDone, clearSeen, inputOvercurrent, thresholdPinLow;
	logic [7:0] regAddr, regWdata, regRdata, inputSenseCode;
	logic [9:0] loadCurrentMonitor, refDac;
	logic [5:0] phaseEnable, lowSideRefresh, refreshSeen;
	logic [2:0] unusedPhaseHigh, activePhases, programmedPhases;
	int         mismatches, testsRun;

	phase_shed_ctrl u_phase_shed_ctrl (.core_clk(core_clk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRdata(regRdata),
		.inputSenseCode(inputSenseCode), .loadCurrentMonitor(loadCurrentMonitor),
		.thresholdLevel(8'h10), .refDac(refDac), .thresholdPinLow(thresholdPinLow),
		.unusedPhaseHigh(unusedPhaseHigh), .fastPhaseAddEvent(fastPhaseAddEvent),
		.overcurrentRetry(overcurrentRetry), .softStartDone(softStartDone),
		.lowPowerStateOne(1'b0), .lowPowerPhaseCount(3'h2),
		.programmedPhases(programmedPhases), .phaseEnable(phaseEnable),
		.lowSideRefresh(lowSideRefresh), .inputOvercurrent(inputOvercurrent),
		.activePhases(activePhases));
	power_stage_model u_power_stage_model (.core_clk(core_clk), .phaseEnable(phaseEnable),
		.lowSideRefresh(lowSideRefresh), .clearSeen(clearSeen),
		.unusedPhaseHigh(unusedPhaseHigh), .refreshSeen(refreshSeen));

	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic report_and_stop();
		$display("mismatches=%0d comparisons=%0d", mismatches, testsRun);
		if (mismatches == 0 && testsRun > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	// register answer lands one cycle after the address; sample after the next edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		repeat (2) @(posedge core_clk);
		#1 d = regRdata;
	endtask

	// bounded wait for the phase count; looks after each edge has settled
	task automatic waitPh(input logic [2:0] n, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge core_clk);
			#1;
			if (activePhases === n) break;
		end
		chk({5'h0, activePhases}, {5'h0, n});
	endtask

	task automatic regTest();
		logic [7:0] d;
		rd(`ADDR_SHED_CONFIG, d);  chk(d, `RST_SHED_CONFIG);
		rd(`ADDR_MODE_CONTROL, d); chk(d, `RST_MODE_CONTROL);
		rd(`ADDR_OC_CONFIG, d);    chk(d, `RST_OC_CONFIG);
		rd(8'h55, d);              chk(d, 8'h00);
		wr(`ADDR_OFFSET_TRIM, 8'hff);
		rd(`ADDR_OFFSET_TRIM, d);  chk(d, 8'h1f);
		wr(`ADDR_SHED_CONFIG, 8'ha4);
		rd(`ADDR_SHED_CONFIG, d);  chk(d, 8'ha4);
		wr(`ADDR_SHED_CONFIG, 8'h00);
	endtask

	task automatic inputTest();
		logic [7:0] d;
		inputSenseCode <= 8'h50;
		rd(`ADDR_INPUT_CURRENT, d); chk(d, 8'h14);
		inputSenseCode <= 8'hff;
		rd(`ADDR_INPUT_CURRENT, d); chk(d, `IIN_FULL_CODE);
		for (int f = 0; f < 4; f++) begin
			wr(`ADDR_OC_CONFIG, 8'(f << 5));
			inputSenseCode <= 8'(8'h2d + 8 * f);
			repeat (3) @(posedge core_clk);
			#1 chk({7'h0, inputOvercurrent}, 8'h00);
			@(posedge core_clk);
			inputSenseCode <= 8'(8'h2e + 8 * f);
			repeat (3) @(posedge core_clk);
			#1 chk({7'h0, inputOvercurrent}, 8'h01);
		end
		inputSenseCode <= 8'h00;
	endtask

	task automatic fixedTest();
		logic [5:0] m [6] = '{6'h01, 6'h09, 6'h0b, 6'h1b, 6'h1f, 6'h3f};
		wr(`ADDR_MODE_CONTROL, 8'h0c);
		for (int n = 1; n <= 6; n++) begin
			@(posedge core_clk);
			programmedPhases <= 3'(n);
			waitPh(3'(n), 20);
			chk({2'h0, phaseEnable}, {2'h0, m[n-1]});
		end
	endtask

	task automatic autoTest();
		wr(`ADDR_MODE_CONTROL, 8'h08);
		loadCurrentMonitor <= 10'h000;
		waitPh(3'h1, 500);
		clearSeen <= 1'b1;
		@(posedge core_clk);
		clearSeen <= 1'b0;
		repeat (1300) @(posedge core_clk);
		#1 chk({2'h0, refreshSeen}, 8'h3e);
		refDac <= `REF_STOP_CODE;
		repeat (10) @(posedge core_clk);
		clearSeen <= 1'b1;
		@(posedge core_clk);
		clearSeen <= 1'b0;
		repeat (1300) @(posedge core_clk);
		#1 chk({2'h0, refreshSeen}, 8'h00);
		refDac <= 10'h3ff;
		// trimmed load just above the first trip but inside its hysteresis
		loadCurrentMonitor <= 10'h137;
		repeat (20) @(posedge core_clk);
		#1 chk({5'h0, activePhases}, 8'h01);
		loadCurrentMonitor <= 10'h14b;
		waitPh(3'h2, 20);
		repeat (20) @(posedge core_clk);
		#1 chk({5'h0, activePhases}, 8'h02);
		loadCurrentMonitor <= 10'h3ff;
		waitPh(3'h6, 50);
		loadCurrentMonitor <= 10'h000;
		waitPh(3'h1, 50);
	endtask

	task automatic restoreTest();
		// fast add off: rising load must not bring phases back
		wr(`ADDR_MODE_CONTROL, 8'h00);
		loadCurrentMonitor <= 10'h3ff;
		repeat (300) @(posedge core_clk);
		#1 chk({5'h0, activePhases}, 8'h01);
		overcurrentRetry <= 1'b1;
		waitPh(3'h6, 10);
		overcurrentRetry <= 1'b0;
		loadCurrentMonitor <= 10'h000;
		waitPh(3'h1, 500);
		wr(`ADDR_MODE_CONTROL, 8'h08);
		fastPhaseAddEvent <= 1'b1;
		waitPh(3'h6, 6);
		chk({2'h0, phaseEnable}, 8'h3f);
		fastPhaseAddEvent <= 1'b0;
		// grounded threshold pin forces the programmed count
		programmedPhases <= 3'h3;
		thresholdPinLow <= 1'b1;
		repeat (10) @(posedge core_clk);
		#1 chk({5'h0, activePhases}, 8'h03);
		thresholdPinLow <= 1'b0;
	endtask

	// watchdog sized well past the expected run
	initial begin
		#(40 * 60000);
		mismatches++;
		report_and_stop();
	end

	initial begin
		mismatches = 0;
		testsRun = 0;
		resetn = 1'b0;
		{regWrite, fastPhaseAddEvent, overcurrentRetry, softStartDone, clearSeen} = 5'h0;
		thresholdPinLow = 1'b0;
		{regAddr, regWdata, inputSenseCode} = 24'h0;
		loadCurrentMonitor = 10'h000;
		refDac = 10'h3ff;
		programmedPhases = 3'h6;
		repeat (6) @(posedge core_clk);
		#1 chk({2'h0, phaseEnable}, 8'h3f);
		chk({5'h0, activePhases}, 8'h06);
		resetn <= 1'b1;
		regTest();
		inputTest();
		softStartDone <= 1'b1;
		fixedTest();
		autoTest();
		restoreTest();
		report_and_stop();
	end
endmodule
`default_nettype wire
